// File: hw/temp_conversion_rate_limit_compare.sv
/*
  Conversion scheduling and limit comparison of a three channel
  temperature monitor. Assumes a serial bus engine outside that turns
  bus writes into one-cycle reg_req strobes and samples reg_rdata, and
  an analog front end that answers each adc_start with one done pulse.
*/
`timescale 1ns/1ps
`default_nettype none
`include "temp_monitor_params.svh"

module temp_conversion_rate_limit_compare
  import temp_monitor_pkg::*;
#(
  parameter int unsigned BASE_PERIOD_CYC = `BASE_PERIOD_CYC,
  parameter int unsigned FAST_PERIOD_CYC = `FAST_PERIOD_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire reg_req_s    reg_req,
  output logic [7:0]       reg_rdata,
  input  wire adc_result_s adc_res,
  output logic             adc_start,
  output logic [1:0]       adc_channel,
  output logic             adc_average,
  output logic             temp_range_ext,
  output logic             over_temp_output_n,
  output logic             pin8_n
);

  core_state_s q;
  core_state_s n;
  logic        standby;
  logic        cont;
  logic        tick;
  logic [2:0]  mask;
  logic [2:0]  start_bit;
  logic [1:0]  c;
  logic [9:0]  r;
  logic [9:0]  hi_c;
  logic [9:0]  lo_c;
  logic [9:0]  th_c;
  logic [9:0]  hy_c;
  logic [2:0]  kind;

  // -----------------------------------------------------------------
  // scheduling
  // -----------------------------------------------------------------
  function automatic logic [31:0] period_of(input logic [3:0] code);
    if (code == `RATE_FAST_CODE) begin
      return FAST_PERIOD_CYC;
    end
    return BASE_PERIOD_CYC >> code;
  endfunction

  always_comb begin
    n         = q;
    n.adc_start = 1'b0;
    start_bit = 3'b000;
    standby   = q.cfg[`CFG_STANDBY_BIT];
    // codes above continuous also run back to back
    cont      = q.rate[3:0] >= `RATE_CONT_CODE;
    tick      = !standby && (cont ? (q.st == ST_IDLE && q.pending == 3'b000)
                                  : (q.tick_cnt >= period_of(q.rate[3:0]) - 32'd1));
    case (q.rate[5:4])
      2'b00:   mask = 3'b111;
      2'b01:   mask = 3'b001;
      2'b10:   mask = 3'b010;
      default: mask = 3'b100;
    endcase
    if (standby || cont || tick) begin
      n.tick_cnt = 32'h0;
    end else begin
      n.tick_cnt = q.tick_cnt + 32'h1;
    end
    c    = q.chan;
    r    = {adc_res.msb, (c == 2'd0) ? 2'b00 : adc_res.lsb[7:6]};
    hi_c = {q.hi_msb[c], (c == 2'd0) ? 2'b00 : q.hi_lsb[c][7:6]};
    lo_c = {q.lo_msb[c], (c == 2'd0) ? 2'b00 : q.lo_lsb[c][7:6]};
    th_c = {q.over_temp_output_lim[c], 2'b00};
    hy_c = {q.hyst, 2'b00};
    case (q.st)
      ST_IDLE: begin
        if (!standby && q.pending != 3'b000) begin
          n.adc_start = 1'b1;
          n.st        = ST_WAIT;
          if (q.pending[0]) begin
            n.chan = 2'd0;
          end else if (q.pending[1]) begin
            n.chan = 2'd1;
          end else begin
            n.chan = 2'd2;
          end
          start_bit = 3'b001 << n.chan;
        end
      end
      ST_WAIT: begin
        // standby abandons the conversion under way
        if (standby) begin
          n.st = ST_IDLE;
        end else if (adc_res.done) begin
          n.st         = ST_IDLE;
          n.val_msb[c] = adc_res.msb;
          n.val_lsb[c] = (c == 2'd0) ? 8'h00 : adc_res.lsb;
          // raw codes compared as stored, binary or offset alike
          n.hi_flag[c] = r > hi_c;
          n.lo_flag[c] = r <= lo_c;
          if (r > th_c) begin
            n.over_temp_output_act[c] = 1'b1;
          end else if ({1'b0, r} + {1'b0, hy_c} < {1'b0, th_c}) begin
            n.over_temp_output_act[c] = 1'b0;
          end
          if (r > hi_c) begin
            n.hi_act[c] = 1'b1;
          end else if ({1'b0, r} + {1'b0, hy_c} < {1'b0, hi_c}) begin
            n.hi_act[c] = 1'b0;
          end
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    n.pending = standby ? 3'b000 : ((q.pending & ~start_bit) | (tick ? mask : 3'b000));
    // -----------------------------------------------------------------
    // register writes
    // -----------------------------------------------------------------
    kind = reg_req.addr[4:2];
    if (reg_req.wr) begin
      case (reg_req.addr)
        `ADDR_RATE_WR: n.rate = reg_req.wdata & `RATE_RSVD_MASK;
        `ADDR_CFG_WR:  n.cfg  = reg_req.wdata;
        `ADDR_HYST:    n.hyst = reg_req.wdata;
        default: begin
          if (reg_req.addr[7:5] == `LIMIT_BASE_HI && reg_req.addr[1:0] != 2'd3) begin
            case (kind)
              3'd0:    n.hi_msb[reg_req.addr[1:0]]    = reg_req.wdata;
              3'd1:    n.hi_lsb[reg_req.addr[1:0]]    = reg_req.wdata;
              3'd2:    n.lo_msb[reg_req.addr[1:0]]    = reg_req.wdata;
              3'd3:    n.lo_lsb[reg_req.addr[1:0]]    = reg_req.wdata;
              3'd4:    n.over_temp_output_lim[reg_req.addr[1:0]] = reg_req.wdata;
              default: n.hyst = q.hyst;
            endcase
          end
        end
      endcase
    end
    // -----------------------------------------------------------------
    // register reads
    // -----------------------------------------------------------------
    case (reg_req.addr)
      `ADDR_LOCAL_VAL:  n.rdata = q.val_msb[0];
      `ADDR_R1_VAL_MSB: n.rdata = q.val_msb[1];
      `ADDR_R1_VAL_LSB: n.rdata = q.val_lsb[1];
      `ADDR_R2_VAL_MSB: n.rdata = q.val_msb[2];
      `ADDR_R2_VAL_LSB: n.rdata = q.val_lsb[2];
      `ADDR_STATUS1:    n.rdata = {q.st == ST_WAIT, q.hi_flag[0], q.lo_flag[0], q.hi_flag[1],
                                   q.lo_flag[1], 1'b0, q.over_temp_output_act[1], q.over_temp_output_act[0]};
      `ADDR_STATUS2:    n.rdata = {3'b000, q.hi_flag[2], q.lo_flag[2], 1'b0, q.over_temp_output_act[2], 1'b0};
      `ADDR_CFG_RD:     n.rdata = q.cfg;
      `ADDR_RATE_RD:    n.rdata = q.rate;
      `ADDR_HYST:       n.rdata = q.hyst;
      default: begin
        n.rdata = 8'h00;
        if (reg_req.addr[7:5] == `LIMIT_BASE_HI && reg_req.addr[1:0] != 2'd3) begin
          case (kind)
            3'd0:    n.rdata = q.hi_msb[reg_req.addr[1:0]];
            3'd1:    n.rdata = q.hi_lsb[reg_req.addr[1:0]];
            3'd2:    n.rdata = q.lo_msb[reg_req.addr[1:0]];
            3'd3:    n.rdata = q.lo_lsb[reg_req.addr[1:0]];
            3'd4:    n.rdata = q.over_temp_output_lim[reg_req.addr[1:0]];
            default: n.rdata = 8'h00;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      q         <= '0;
      q.rate    <= `RATE_RESET;
      q.cfg     <= `CFG_RESET;
      q.hyst    <= `HYST_RESET;
      q.hi_msb    <= {3{`HIGH_LIM_RESET}};
      q.lo_msb    <= {3{`LOW_LIM_RESET}};
      q.over_temp_output_lim <= {3{`OVER_TEMP_OUTPUT_LIM_RESET}};
    end else begin
      q <= n;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign reg_rdata      = q.rdata;
  assign adc_start      = q.adc_start;
  assign adc_channel    = q.chan;
  // the three fastest timed codes leave no time to average
  assign adc_average    = !q.rate[`RATE_NOAVG_BIT] &&
                          (q.rate[3:0] < `RATE_NOAVG_MIN || q.rate[3:0] >= `RATE_CONT_CODE);
  assign temp_range_ext = q.cfg[`CFG_RANGE_BIT];
  assign over_temp_output_n = ~|q.over_temp_output_act;
  assign pin8_n = q.cfg[`CFG_PIN8_BIT] ? ~|q.hi_act : ~|(q.hi_flag | q.lo_flag);

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_rate_write;
    @(posedge core_clk) disable iff (!rstn)
    reg_req.wr && reg_req.addr == `ADDR_RATE_WR |=>
      q.rate == ($past(reg_req.wdata) & `RATE_RSVD_MASK);
  endproperty
  a_rate_write: assert property (p_rate_write)
    else $error("rate write not taken");

  property p_rate_reset;
    @(posedge core_clk) !rstn |=> q.rate == `RATE_RESET;
  endproperty
  a_rate_reset: assert property (p_rate_reset)
    else $error("rate reset value wrong");

  property p_standby;
    @(posedge core_clk) disable iff (!rstn)
    q.cfg[`CFG_STANDBY_BIT] && !(reg_req.wr && reg_req.addr == `ADDR_CFG_WR) |=> !q.adc_start[*2];
  endproperty
  a_standby: assert property (p_standby)
    else $error("conversion started in standby");

  property p_single_local;
    @(posedge core_clk) disable iff (!rstn)
    tick && q.st == ST_IDLE && q.pending == 3'b000 && q.rate[5:4] == 2'b01 && !reg_req.wr
      |-> ##2 (q.adc_start && q.chan == 2'd0);
  endproperty
  a_single_local: assert property (p_single_local)
    else $error("local only selection not honoured");

  property p_continuous;
    @(posedge core_clk) disable iff (!rstn)
    q.rate[3:0] == `RATE_CONT_CODE && q.st == ST_IDLE && q.pending == 3'b000 &&
      !standby && !reg_req.wr |-> ##2 q.adc_start;
  endproperty
  a_continuous: assert property (p_continuous)
    else $error("continuous mode idles");

  property p_high_flag;
    @(posedge core_clk) disable iff (!rstn)
    q.st == ST_WAIT && adc_res.done && !standby && r > hi_c |=> q.hi_flag[$past(q.chan)];
  endproperty
  a_high_flag: assert property (p_high_flag)
    else $error("high limit flag missed");

  property p_low_flag;
    @(posedge core_clk) disable iff (!rstn)
    q.st == ST_WAIT && adc_res.done && !standby && r <= lo_c |=> q.lo_flag[$past(q.chan)];
  endproperty
  a_low_flag: assert property (p_low_flag)
    else $error("low limit flag missed");

  property p_over_temp_output_out;
    @(posedge core_clk) disable iff (!rstn)
    q.st == ST_WAIT && adc_res.done && !standby && r > th_c |=> !over_temp_output_n;
  endproperty
  a_over_temp_output_out: assert property (p_over_temp_output_out)
    else $error("over-temp output not asserted");

  property p_second_over_temp_output_out;
    @(posedge core_clk) disable iff (!rstn)
    q.st == ST_WAIT && adc_res.done && !standby && r > hi_c && q.cfg[`CFG_PIN8_BIT] &&
      !reg_req.wr |=> !pin8_n;
  endproperty
  a_second_over_temp_output_out: assert property (p_second_over_temp_output_out)
    else $error("second over-temp output not asserted");

  property p_hyst_hold;
    @(posedge core_clk) disable iff (!rstn)
    q.over_temp_output_act[q.chan] && q.st == ST_WAIT && adc_res.done &&
      ({1'b0, r} + {1'b0, hy_c} >= {1'b0, th_c}) |=> q.over_temp_output_act[$past(q.chan)];
  endproperty
  a_hyst_hold: assert property (p_hyst_hold)
    else $error("over-temp released inside hysteresis");

endmodule
`default_nettype wire

// File: hw/temp_monitor_params.svh
/*
  Constants of the conversion scheduler and limit comparator: register
  addresses, field positions, reset values and timing counts.
  Assumes a 40 MHz core clock and byte-wide registers.
*/
`ifndef TEMP_MONITOR_PARAMS_SVH
`define TEMP_MONITOR_PARAMS_SVH

// -----------------------------------------------------------------
// register addresses
// -----------------------------------------------------------------
`define ADDR_LOCAL_VAL     8'h00
`define ADDR_R1_VAL_MSB    8'h01
`define ADDR_STATUS1       8'h02
`define ADDR_CFG_RD        8'h03
`define ADDR_RATE_RD       8'h04
`define ADDR_CFG_WR        8'h09
`define ADDR_RATE_WR       8'h0A
`define ADDR_R1_VAL_LSB    8'h10
`define ADDR_HYST          8'h21
`define ADDR_STATUS2       8'h23
`define ADDR_R2_VAL_MSB    8'h30
`define ADDR_R2_VAL_LSB    8'h33
`define LIMIT_BASE_HI      3'b010
`define LIMIT_KINDS        3'd5

// -----------------------------------------------------------------
// fields
// -----------------------------------------------------------------
`define RATE_NOAVG_BIT     7
`define RATE_RSVD_MASK     8'hBF
`define RATE_FAST_CODE     4'hA
`define RATE_CONT_CODE     4'hB
`define RATE_NOAVG_MIN     4'h8
`define CFG_STANDBY_BIT    6
`define CFG_PIN8_BIT       5
`define CFG_RANGE_BIT      2

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define RATE_RESET         8'h08
`define CFG_RESET          8'h00
`define HYST_RESET         8'h0A
`define HIGH_LIM_RESET     8'h55
`define LOW_LIM_RESET      8'h00
`define OVER_TEMP_OUTPUT_LIM_RESET    8'h55

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define CLK_MHZ            40
`define BASE_PERIOD_S      16
`define FAST_PERIOD_US     15500
`define BASE_PERIOD_CYC    (`BASE_PERIOD_S * `CLK_MHZ * 1000000)
`define FAST_PERIOD_CYC    (`FAST_PERIOD_US * `CLK_MHZ)

`endif

// File: hw/temp_monitor_pkg.sv
/*
  Types of the conversion scheduler and limit comparator.
  Assumes the constants header is available on the include path.
*/
package temp_monitor_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } conv_state_e;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic       done;
    logic [7:0] msb;
    logic [7:0] lsb;
  } adc_result_s;

  typedef struct packed {
    conv_state_e     st;
    logic [7:0]      rate;
    logic [7:0]      cfg;
    logic [7:0]      hyst;
    logic [2:0][7:0] hi_msb;
    logic [2:0][7:0] hi_lsb;
    logic [2:0][7:0] lo_msb;
    logic [2:0][7:0] lo_lsb;
    logic [2:0][7:0] over_temp_output_lim;
    logic [2:0][7:0] val_msb;
    logic [2:0][7:0] val_lsb;
    logic [2:0]      hi_flag;
    logic [2:0]      lo_flag;
    logic [2:0]      over_temp_output_act;
    logic [2:0]      hi_act;
    logic [2:0]      pending;
    logic [1:0]      chan;
    logic            adc_start;
    logic [31:0]     tick_cnt;
    logic [7:0]      rdata;
  } core_state_s;

endpackage

// File: tb/adc_front_model.sv
/*
  Behavioural analog front end: answers each adc_start with one done
  pulse carrying the programmed temperature of the selected channel.
  Assumes the scheduler holds adc_channel steady while a conversion runs.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_front_model
  import temp_monitor_pkg::*;
#(
  parameter int DELAY = 1
) (
  input  wire logic            core_clk,
  input  wire logic            rstn,
  input  wire logic            adc_start,
  input  wire logic [1:0]      adc_channel,
  input  wire logic            range_ext,
  input  wire logic [2:0][7:0] temp,
  output var adc_result_s      adc_res
);
  // -----------------------------------------------------------------
  // conversion
  // -----------------------------------------------------------------
  int          cnt;
  logic [15:0] last;
  logic [7:0]  code;

  // extended range adds 64 to the reported value
  assign code = temp[adc_channel] + (range_ext ? 8'h40 : 8'h00);

  always @(posedge core_clk) begin
    if (!rstn) begin
      cnt <= 0;
      last <= 16'h0000;
      adc_res <= '0;
    end else if (cnt == 1) begin
      cnt <= 0;
      adc_res <= '{done: 1'b1, msb: code, lsb: 8'h40};
      last <= {code, 8'h40};
    end else begin
      // bytes are not held outside the done cycle, so show a changing value
      adc_res <= '{done: 1'b0, msb: ~last[15:8], lsb: ~last[7:0]};
      last <= ~last;
      if (adc_start) begin
        cnt <= DELAY + 1;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

`default_nettype wire

// File: tb/test_temp_conversion_rate_limit_compare.sv
/*
  Register level testbench of the scheduler and limit comparator.
  Assumes the front end model of this folder and shortened periods.
*/
`timescale 1ns/1ps
`default_nettype none
`include "temp_monitor_params.svh"

module test_temp_conversion_rate_limit_compare
  import temp_monitor_pkg::*;
;
  // -----------------------------------------------------------------
  // design and front end
  // -----------------------------------------------------------------
  localparam int BASE = 4096;
  localparam int FAST = 16;
  localparam logic [7:0] TT [10] = '{8'd81, 8'd80, 8'd10, 8'd11, 8'd91,
                                     8'd85, 8'd79, 8'd81, 8'd75, 8'd69};
  // {pin8 function, high flag, low flag, over temp, pin8}
  // limits: high 80, low 10, over temp 90, hysteresis 10
  localparam logic [4:0] EX [10] = '{5'h0A, 5'h03, 5'h06, 5'h03, 5'h18,
                                     5'h18, 5'h12, 5'h1A, 5'h12, 5'h13};

  logic            core_clk;
  logic            rstn;
  reg_req_s        reg_req;
  logic [7:0]      reg_rdata;
  adc_result_s     adc_res;
  logic            adc_start;
  logic [1:0]      adc_channel;
  logic            adc_average;
  logic            temp_range_ext;
  logic            over_temp_output_n;
  logic            pin8_n;
  logic [2:0][7:0] temp;
  logic [7:0]      v;
  int              n_mismatch;
  int              check_count;
  int              n;
  int              ch;

  temp_conversion_rate_limit_compare #(
    .BASE_PERIOD_CYC(BASE),
    .FAST_PERIOD_CYC(FAST)
  ) u_dut (
    .core_clk           (core_clk),
    .rstn               (rstn),
    .reg_req            (reg_req),
    .reg_rdata          (reg_rdata),
    .adc_res            (adc_res),
    .adc_start          (adc_start),
    .adc_channel        (adc_channel),
    .adc_average        (adc_average),
    .temp_range_ext     (temp_range_ext),
    .over_temp_output_n (over_temp_output_n),
    .pin8_n             (pin8_n)
  );

  adc_front_model u_adc (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .adc_start   (adc_start),
    .adc_channel (adc_channel),
    .range_ext   (temp_range_ext),
    .temp        (temp),
    .adc_res     (adc_res)
  );

  always #12.5 core_clk = ~core_clk;

  // -----------------------------------------------------------------
  // tasks
  // -----------------------------------------------------------------
  task automatic step();
    @(posedge core_clk);
    #2;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = '{wr: 1'b1, addr: a, wdata: d};
    step();
    reg_req.wr = 1'b0;
    // one idle edge so a following write never re-raises the strobe at once
    step();
  endtask

  // address held two edges so the registered read data has caught up
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_req.addr = a;
    step();
    step();
    d = reg_rdata;
  endtask

  task automatic gap(input int limit, output int k);
    k = 0;
    do begin
      step();
      k++;
    end while (adc_start !== 1'b1 && k < limit);
  endtask

  // two results, so one whole conversion began after the last change
  task automatic settle();
    int k;
    repeat (2) begin
      k = 0;
      do begin
        step();
        k++;
      end while (adc_res.done !== 1'b1 && k < 500);
      chk("result arrives", k < 500, 1);
    end
    repeat (3) step();
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    repeat (5) step();
    rstn = 1'b1;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // -----------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    core_clk = 1'b0;
    reg_req = '0;
    temp = {8'd50, 8'd40, 8'd25};
    n_mismatch = 0;
    check_count = 0;
    do_reset();
    rd(`ADDR_RATE_RD, v);
    chk("rate reset", v, `RATE_RESET);
    rd(`ADDR_HYST, v);
    chk("hysteresis reset", v, `HYST_RESET);
    rd(`ADDR_RATE_WR, v);
    chk("write address read", v, 8'h00);
    wr(`ADDR_RATE_WR, 8'hFF);
    rd(`ADDR_RATE_RD, v);
    chk("reserved bit", v, 8'hBF);
    for (int i = 0; i < 32; i++) begin
      wr(`ADDR_RATE_WR, {i[4], 3'b000, i[3:0]});
      chk("adc_average", adc_average, !i[4] && (i[3:0] < 8 || i[3:0] > 10));
    end
    // fresh counter; a count already past a shorter new period ticks at once
    do_reset();
    for (int c = 10; c >= 0; c--) begin
      wr(`ADDR_RATE_WR, 8'h10 | c[7:0]);
      gap(10000, n);
      gap(10000, n);
      chk("period", n, c == 10 ? FAST : BASE >> c);
    end
    for (int s = 0; s < 4; s++) begin
      wr(`ADDR_RATE_WR, {2'b00, s[1:0], 4'hB});
      gap(10000, n);
      gap(10000, n);
      ch = adc_channel;
      repeat (3) begin
        gap(10000, n);
        chk("continuous gap", n <= 10, 1);
        chk("channel", adc_channel, s == 0 ? (ch + 1) % 3 : s - 1);
        ch = adc_channel;
      end
    end
    temp[1] = 8'd99;
    wr(`ADDR_RATE_WR, 8'h1B);
    wr(8'h40, 8'd80);
    wr(8'h48, 8'd10);
    wr(8'h50, 8'd90);
    for (int i = 0; i < 10; i++) begin
      wr(`ADDR_CFG_WR, {2'b00, EX[i][4], 5'b00000});
      temp[0] = TT[i];
      settle();
      rd(`ADDR_STATUS1, v);
      chk("local flags", v[6:5], EX[i][3:2]);
      chk("over temp", over_temp_output_n, EX[i][1]);
      chk("pin8", pin8_n, EX[i][0]);
    end
    rd(`ADDR_R1_VAL_MSB, v);
    chk("unmeasured remote", v, 8'd40);
    wr(`ADDR_CFG_WR, 8'h04);
    temp[0] = 8'd30;
    settle();
    rd(`ADDR_LOCAL_VAL, v);
    chk("extended value", v, 8'd94);
    rd(`ADDR_STATUS1, v);
    chk("raw high compare", v[6], 1'b1);
    rd(8'h40, v);
    chk("limit kept", v, 8'd80);
    wr(8'h45, 8'hC0);
    rd(8'h45, v);
    chk("remote high low byte", v, 8'hC0);
    wr(`ADDR_CFG_WR, 8'h44);
    repeat (3) step();
    gap(300, n);
    chk("standby starts", n, 300);
    rd(`ADDR_RATE_RD, v);
    chk("standby access", v, 8'h1B);
    wr(`ADDR_CFG_WR, 8'h04);
    gap(100, n);
    chk("resume", n < 100, 1);
    report_and_stop();
  end
endmodule

`default_nettype wire
